/* src/mocs_pkg.sv */
/*
  Package for the option and clock setup block: register offsets, field
  positions, reset values, option encodings and carrier structs.
  Assumes a 32-bit APB master and a single 250 MHz core clock.
*/
package mocs_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_OPTION     = 8'h00;
  localparam logic [7:0] OFS_CLOCK_MODE = 8'h04;
  localparam logic [7:0] OFS_CRYSTAL    = 8'h08;
  localparam logic [7:0] OFS_PWM_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h10;
  localparam logic [7:0] OFS_TIMER_SCAL = 8'h14;
  localparam logic [7:0] OFS_PORT_DIR   = 8'h18;
  localparam logic [7:0] OFS_DIG_IN_EN  = 8'h1C;
  localparam logic [7:0] OFS_INT_EN     = 8'h20;
  localparam logic [7:0] OFS_INT_REQ    = 8'h24;
  localparam logic [7:0] OFS_CPU_CTRL   = 8'h28;
  localparam logic [7:0] OFS_STATUS     = 8'h2C;
  localparam logic [7:0] OFS_COMP_CTRL  = 8'h30;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CMODE_RST_PIN_BIT  = 0;
  localparam int CMODE_SLOW_EN_BIT  = 2;
  localparam int CMODE_SEL_LSB      = 5;
  localparam int CMODE_SEL_MSB      = 7;
  localparam int XTAL_RANGE_LSB     = 5;
  localparam int XTAL_RANGE_MSB     = 6;
  localparam int XTAL_EN_BIT        = 7;
  localparam int PWM_CLK_EN_BIT     = 0;
  localparam int TMR_SRC_LSB        = 4;
  localparam int TMR_SRC_MSB        = 7;
  localparam int TMR_LOWRES_BIT     = 7;
  localparam int COMP_GATE_BIT      = 6;
  localparam int CPU_ENTER_ISR_BIT  = 0;
  localparam int CPU_RETI_BIT       = 1;
  localparam int CPU_GIE_SET_BIT    = 2;
  localparam int CPU_GIE_CLR_BIT    = 3;
  localparam int PA_PIN_FIVE        = 5;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [3:0] TMR_SRC_FAST   = 4'h2;
  localparam logic [1:0] XTAL_LOW       = 2'h1;
  localparam logic [1:0] XTAL_MID       = 2'h2;
  localparam logic [1:0] XTAL_HIGH      = 2'h3;
  localparam logic [7:0] CMODE_RESET    = 8'hF4;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam int         FAST_OSC_MHZ   = 16;
  localparam int         PWM_CHANNELS   = 3;
  localparam int         TIMER_CHANNELS = 2;

  typedef enum logic [1:0] {
    MOCS_EDGE_ALL     = 2'b00,
    MOCS_EDGE_RISING  = 2'b01,
    MOCS_EDGE_FALLING = 2'b10
  } mocs_edge_t;

  typedef struct packed {
    logic       read_protect;
    logic       pwm_double;
    logic       comp_gates_pwm;
    logic       int0_alt_pin;
    logic       int1_alt_pin;
    mocs_edge_t comp_edge;
    logic       timer_double;
    logic       timer_7bit;
  } mocs_option_t;

  typedef struct packed {
    logic       on;
    logic [1:0] range;
  } mocs_xtal_t;

endpackage : mocs_pkg

/* src/mocs_top.sv */
/*
  Option loader and clock setup for a small 8-bit controller core, as an
  APB slave. Holds the code options, clock mode, crystal, interrupt and
  pin-role configuration and derives the steering outputs from them.
  Assumes options arrive from nonvolatile memory while rstn is low, and
  that pins and comparator result are synchronous to core_clk.
*/
// What this block does
// - Read protection set refuses program readback; cleared allows it.
// - Enabled PWM generators clock from fast oscillator, 16 or doubled 32MHz.
// - Gating option off keeps comparator and PWM independent; on, comparator gates.
// - Interrupt bit 0 comes from port A pin 0 or port B pin 5.
// - Interrupt bit 1 comes from port B pin 0 or port A pin 4.
// - Default comparator edge option interrupts on both edges.
// - Single-polarity option interrupts on rising only or falling only.
// - Timer source nibble 0010 picks fast oscillator, 16 or 32MHz.
// - Timer scaler bit 7 gives 6-bit PWM, or 7-bit by option.
// - Port A pin five is open drain; never driven high.
// - Pin five as input with clock mode bit 0 becomes external reset.
// - Port A input pin with digital-input enable bit set may wake the device; port B wake enables copy port A's.
// - Crystal range field: 01 low, 10 mid, 11 high frequency.
// - Crystal control bit 7 starts the crystal; cleared keeps it off.
// - No crystal-stable check on switch; software waits before selecting.
// - Clearing clock mode bit 2 after switching stops the slow oscillator.
// - Entering service clears global interrupt enable.
// - Return from interrupt restores global interrupt enable.
// - Interrupt enable and request are undefined after reset; software writes both.
// - Watchdog stops and cannot reset while slow oscillator is off.
// - Gating on forces PWM outputs low while comparator control bit 6 is 1.
module mocs_top #(
  parameter  int PA_WIDTH  = 8,
  parameter  int PB_WIDTH  = 8,
  localparam int PWM_RAW_W = mocs_pkg::PWM_CHANNELS + mocs_pkg::TIMER_CHANNELS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [31:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire mocs_pkg::mocs_option_t option_nvm,
  input  wire logic                  prog_read_req,
  input  wire logic [15:0]           prog_word_in,
  output logic      [15:0]           prog_word_out,
  input  wire logic [PA_WIDTH-1:0]   port_a_in,
  input  wire logic [PB_WIDTH-1:0]   port_b_in,
  input  wire logic                  pin5_out_low,
  input  wire logic                  comparator_out,
  input  wire logic [PWM_RAW_W-1:0]  pwm_raw,
  output logic      [PWM_RAW_W-1:0]  pwm_out,
  output logic                       port_a_pin_five_o,
  output logic                       port_a_pin_five_oe,
  output logic                       external_reset,
  output logic [PA_WIDTH-1:0]        wake_a_en,
  output logic [PB_WIDTH-1:0]        wake_b_en,
  output logic [1:0]                 ext_int_req,
  output logic                       comp_int_req,
  output logic                       global_int_en,
  output logic [2:0]                 pwm_clk_en,
  output logic [2:0]                 pwm_clk_double,
  output logic [1:0]                 timer_clk_fast,
  output logic [1:0]                 timer_clk_double,
  output logic [1:0]                 timer_pwm_7bit,
  output logic [1:0]                 timer_pwm_lowres,
  output mocs_pkg::mocs_xtal_t       xtal_ctrl,
  output logic                       slow_osc_en,
  output logic [2:0]                 sys_clk_sel,
  output logic                       watchdog_run
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  mocs_pkg::mocs_option_t opt_q;
  logic                   opt_loaded_q;
  logic [7:0] cmode_q, cmode_d;
  logic [7:0] xtal_q, pwmc_q, tmrc_q, tscal_q, comp_q;
  logic [PA_WIDTH-1:0] pa_dir_q, pa_die_q;
  logic [7:0] inten_q, intrq_q, intrq_d;
  logic       gie_q, gie_d;
  logic       comp_prev_q;
  logic [1:0] pin_prev_q;
  logic       access_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        setup_ph  = psel & ~penable;
  wire        access_ph = psel & penable & access_q;
  wire        wr_en     = access_ph & pwrite & pstrb[0];
  wire [7:0]  addr      = paddr[7:0];
  wire        hit_cmode = addr == mocs_pkg::OFS_CLOCK_MODE;
  wire        hit_xtal  = addr == mocs_pkg::OFS_CRYSTAL;
  wire        hit_pwmc  = addr == mocs_pkg::OFS_PWM_CTRL;
  wire        hit_tmrc  = addr == mocs_pkg::OFS_TIMER_CTRL;
  wire        hit_tscal = addr == mocs_pkg::OFS_TIMER_SCAL;
  wire        hit_pdir  = addr == mocs_pkg::OFS_PORT_DIR;
  wire        hit_die   = addr == mocs_pkg::OFS_DIG_IN_EN;
  wire        hit_inten = addr == mocs_pkg::OFS_INT_EN;
  wire        hit_intrq = addr == mocs_pkg::OFS_INT_REQ;
  wire        hit_cpu   = addr == mocs_pkg::OFS_CPU_CTRL;
  wire        hit_comp  = addr == mocs_pkg::OFS_COMP_CTRL;
  wire        hit_ro    = (addr == mocs_pkg::OFS_OPTION) | (addr == mocs_pkg::OFS_STATUS);
  wire        mapped    = hit_cmode | hit_xtal | hit_pwmc | hit_tmrc | hit_tscal | hit_pdir |
                          hit_die | hit_inten | hit_intrq | hit_cpu | hit_comp | hit_ro;
  wire        aligned   = paddr[1:0] == 2'h0;
  // Options are read-only; a write there is an error
  wire        bad       = ~mapped | ~aligned | (pwrite & hit_ro);
  wire [7:0]  wbyte     = pwdata[7:0];

  // ****************************************************************
  // Event detection
  // ****************************************************************
  wire [1:0] pin_now = {opt_q.int1_alt_pin ? port_a_in[4] : port_b_in[0],
                        opt_q.int0_alt_pin ? port_b_in[5] : port_a_in[0]};
  wire       comp_rise = comparator_out & ~comp_prev_q;
  wire       comp_fall = ~comparator_out & comp_prev_q;
  logic      comp_evt;
  always_comb begin
    case (opt_q.comp_edge)
      mocs_pkg::MOCS_EDGE_ALL:     comp_evt = comparator_out ^ comp_prev_q;
      mocs_pkg::MOCS_EDGE_RISING:  comp_evt = comp_rise;
      mocs_pkg::MOCS_EDGE_FALLING: comp_evt = comp_fall;
      default:                     comp_evt = comparator_out ^ comp_prev_q;
    endcase
  end
  wire [1:0] pin_evt = pin_now & ~pin_prev_q;
  wire [7:0] evt_vec = {5'h00, comp_evt, pin_evt};

  // ****************************************************************
  // Interrupt request, global enable and clock mode next values
  // ****************************************************************
  wire enter_isr = wr_en & hit_cpu & wbyte[mocs_pkg::CPU_ENTER_ISR_BIT];
  wire do_reti   = wr_en & hit_cpu & wbyte[mocs_pkg::CPU_RETI_BIT];
  wire gie_set   = wr_en & hit_cpu & wbyte[mocs_pkg::CPU_GIE_SET_BIT];
  wire gie_clr   = wr_en & hit_cpu & wbyte[mocs_pkg::CPU_GIE_CLR_BIT];
  always_comb begin
    intrq_d = intrq_q;
    if (wr_en & hit_intrq) begin
      intrq_d = wbyte;
    end
    // A new event beats a software clear in the same cycle
    intrq_d = intrq_d | evt_vec;
    gie_d = gie_q;
    if (gie_set | do_reti) begin
      gie_d = 1'b1;
    end
    if (gie_clr | enter_isr) begin
      gie_d = 1'b0;
    end
    cmode_d = cmode_q;
    // No stability check: the selection is taken as written
    if (wr_en & hit_cmode) begin
      cmode_d = wbyte;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [7:0] opt_byte  = {opt_q.read_protect, opt_q.pwm_double, opt_q.comp_gates_pwm,
                          opt_q.int0_alt_pin, opt_q.int1_alt_pin, opt_q.comp_edge[0],
                          opt_q.timer_double, opt_q.timer_7bit};
  wire [7:0] stat_byte = {4'h0, opt_q.comp_edge[1], watchdog_run, gie_q, external_reset};
  wire [7:0] rd_byte   =
      hit_cmode ? cmode_q :
      hit_xtal  ? xtal_q  :
      hit_pwmc  ? pwmc_q  :
      hit_tmrc  ? tmrc_q  :
      hit_tscal ? tscal_q :
      hit_pdir  ? pa_dir_q[7:0] :
      hit_die   ? pa_die_q[7:0] :
      hit_inten ? inten_q :
      hit_intrq ? intrq_q :
      hit_comp  ? comp_q  :
      (addr == mocs_pkg::OFS_OPTION) ? opt_byte :
      (addr == mocs_pkg::OFS_STATUS) ? stat_byte : mocs_pkg::BYTE_ZERO;

  // ****************************************************************
  // Derived steering
  // ****************************************************************
  wire       slow_on   = cmode_q[mocs_pkg::CMODE_SLOW_EN_BIT];
  wire       pin5_in   = ~pa_dir_q[mocs_pkg::PA_PIN_FIVE];
  // Reset role only when pin is an input and the enable bit is set
  wire       ext_rst_d = pin5_in & cmode_q[mocs_pkg::CMODE_RST_PIN_BIT] &
                         ~port_a_in[mocs_pkg::PA_PIN_FIVE];
  wire       gate_on   = opt_q.comp_gates_pwm & comp_q[mocs_pkg::COMP_GATE_BIT];
  wire       tmr_fast  = tmrc_q[mocs_pkg::TMR_SRC_MSB:mocs_pkg::TMR_SRC_LSB] ==
                         mocs_pkg::TMR_SRC_FAST;
  wire       lowres    = tscal_q[mocs_pkg::TMR_LOWRES_BIT];
  wire [PA_WIDTH-1:0] wake_a_d = ~pa_dir_q & pa_die_q;
  mocs_pkg::mocs_xtal_t xtal_d;
  assign xtal_d.on    = xtal_q[mocs_pkg::XTAL_EN_BIT];
  assign xtal_d.range = xtal_q[mocs_pkg::XTAL_RANGE_MSB:mocs_pkg::XTAL_RANGE_LSB];

  // ****************************************************************
  // Clocked state
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      access_q     <= 1'b0;
      cmode_q      <= mocs_pkg::CMODE_RESET;
      xtal_q       <= mocs_pkg::BYTE_ZERO;
      pwmc_q       <= mocs_pkg::BYTE_ZERO;
      tmrc_q       <= mocs_pkg::BYTE_ZERO;
      tscal_q      <= mocs_pkg::BYTE_ZERO;
      comp_q       <= mocs_pkg::BYTE_ZERO;
      pa_dir_q     <= '0;
      pa_die_q     <= '0;
      gie_q        <= 1'b0;
    end else begin
      access_q <= setup_ph;
      cmode_q  <= cmode_d;
      gie_q    <= gie_d;
      if (wr_en & ~bad) begin
        if (hit_xtal)  xtal_q   <= wbyte;
        if (hit_pwmc)  pwmc_q   <= wbyte;
        if (hit_tmrc)  tmrc_q   <= wbyte;
        if (hit_tscal) tscal_q  <= wbyte;
        if (hit_comp)  comp_q   <= wbyte;
        if (hit_pdir)  pa_dir_q <= wbyte[PA_WIDTH-1:0];
        if (hit_die)   pa_die_q <= wbyte[PA_WIDTH-1:0];
      end
    end
  end

  // Options captured while reset is held, frozen after release
  always_ff @(posedge core_clk) begin
    if (!opt_loaded_q) begin
      opt_q <= option_nvm;
    end
    // Cleared by every reset so a later reset reloads the options
    opt_loaded_q <= rstn;
  end

  // Interrupt enable and request deliberately have no reset value
  always_ff @(posedge core_clk) begin
    intrq_q <= intrq_d;
    if (wr_en & hit_inten) begin
      inten_q <= wbyte;
    end
    comp_prev_q <= comparator_out;
    pin_prev_q  <= pin_now;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata             <= '0;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      prog_word_out      <= '0;
      pwm_out            <= '0;
      port_a_pin_five_o  <= 1'b0;
      port_a_pin_five_oe <= 1'b0;
      external_reset     <= 1'b0;
      wake_a_en          <= '0;
      wake_b_en          <= '0;
      ext_int_req        <= '0;
      comp_int_req       <= 1'b0;
      global_int_en      <= 1'b0;
      pwm_clk_en         <= '0;
      pwm_clk_double     <= '0;
      timer_clk_fast     <= '0;
      timer_clk_double   <= '0;
      timer_pwm_7bit     <= '0;
      timer_pwm_lowres   <= '0;
      xtal_ctrl          <= '0;
      slow_osc_en        <= 1'b1;
      sys_clk_sel        <= '0;
      watchdog_run       <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & bad;
      prdata  <= {24'h000000, rd_byte};
      prog_word_out <= (prog_read_req & ~opt_q.read_protect) ? prog_word_in : 16'h0000;
      pwm_out <= gate_on ? '0 : pwm_raw;
      port_a_pin_five_o  <= 1'b0;
      port_a_pin_five_oe <= ~pin5_in & pin5_out_low;
      external_reset     <= ext_rst_d;
      wake_a_en          <= wake_a_d;
      wake_b_en          <= {PB_WIDTH{1'b0}} | PB_WIDTH'(wake_a_d);
      ext_int_req        <= intrq_q[1:0] & inten_q[1:0];
      comp_int_req       <= intrq_q[2] & inten_q[2];
      global_int_en      <= gie_q;
      for (int i = 0; i < mocs_pkg::PWM_CHANNELS; i++) begin
        pwm_clk_en[i]     <= pwmc_q[i];
        pwm_clk_double[i] <= pwmc_q[i] & opt_q.pwm_double;
      end
      for (int i = 0; i < mocs_pkg::TIMER_CHANNELS; i++) begin
        timer_clk_fast[i]   <= tmr_fast;
        timer_clk_double[i] <= tmr_fast & opt_q.timer_double;
        timer_pwm_lowres[i] <= lowres;
        timer_pwm_7bit[i]   <= lowres & opt_q.timer_7bit;
      end
      xtal_ctrl    <= xtal_d;
      slow_osc_en  <= slow_on;
      sys_clk_sel  <= cmode_q[mocs_pkg::CMODE_SEL_MSB:mocs_pkg::CMODE_SEL_LSB];
      watchdog_run <= slow_on;
    end
  end

endmodule : mocs_top

/* verification/mocs_top_props.sv */
/*
  Concurrent checks on the option and clock setup block, seen at its ports.
  Assumes option_nvm is held constant by the bench after reset release.
*/
module mocs_checker (
  input wire logic                   core_clk,
  input wire logic                   rstn,
  input wire logic [31:0]            paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire mocs_pkg::mocs_option_t option_nvm,
  input wire logic                   prog_read_req,
  input wire logic [15:0]            prog_word_in,
  input wire logic [15:0]            prog_word_out,
  input wire logic                   pin5_out_low,
  input wire logic [4:0]             pwm_raw,
  input wire logic [4:0]             pwm_out,
  input wire logic                   port_a_pin_five_o,
  input wire logic                   port_a_pin_five_oe,
  input wire mocs_pkg::mocs_xtal_t   xtal_ctrl,
  input wire logic                   slow_osc_en,
  input wire logic [2:0]             sys_clk_sel,
  input wire logic                   watchdog_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Write lands on the edge that sees pready; outputs follow one edge later
  wire logic wr_done = psel && penable && pready && pwrite;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_ready_after_setup:
    assert property (psel && !penable |=> pready && penable) else $error("no ready");
  chk_option_refused:
    assert property (psel && !penable && pwrite && paddr == 32'h0 |=> pslverr)
    else $error("option write accepted");
  chk_protect_blanks:
    assert property (prog_read_req && option_nvm.read_protect |=> prog_word_out == 16'h0000)
    else $error("protected word leaked");
  chk_readback_passes:
    assert property (prog_read_req && !option_nvm.read_protect |=>
      prog_word_out == $past(prog_word_in)) else $error("readback wrong");
  chk_pwm_independent:
    assert property (!option_nvm.comp_gates_pwm |=> pwm_out == $past(pwm_raw))
    else $error("pwm altered without gating");
  chk_pwm_only_lowers:
    assert property (1'b1 |-> (pwm_out & ~$past(pwm_raw)) == 5'h00)
    else $error("pwm output raised");
  chk_pin_five_sinks:
    assert property (port_a_pin_five_oe |-> !port_a_pin_five_o && $past(pin5_out_low))
    else $error("pin five driven wrongly");
  chk_xtal_follows:
    assert property (wr_done && paddr == {24'h000000, mocs_pkg::OFS_CRYSTAL} |-> ##2
      xtal_ctrl == {$past(pwdata[7], 2), $past(pwdata[6:5], 2)}) else $error("crystal wrong");
  chk_clock_mode_follows:
    assert property (wr_done && paddr == {24'h000000, mocs_pkg::OFS_CLOCK_MODE} |-> ##2
      slow_osc_en == $past(pwdata[2], 2) && sys_clk_sel == $past(pwdata[7:5], 2))
    else $error("clock mode wrong");
  chk_wdog_needs_slow:
    assert property (!slow_osc_en |-> !watchdog_run) else $error("watchdog runs");
  cover property (option_nvm.comp_gates_pwm && pwm_raw != 5'h00 && pwm_out == 5'h00);
  cover property (port_a_pin_five_oe);
  cover property (pslverr);
  cover property (!slow_osc_en);
endmodule : mocs_checker

bind mocs_top mocs_checker u_chk (
  .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .option_nvm(option_nvm), .prog_read_req(prog_read_req), .prog_word_in(prog_word_in),
  .prog_word_out(prog_word_out), .pin5_out_low(pin5_out_low), .pwm_raw(pwm_raw),
  .pwm_out(pwm_out), .port_a_pin_five_o(port_a_pin_five_o),
  .port_a_pin_five_oe(port_a_pin_five_oe), .xtal_ctrl(xtal_ctrl),
  .slow_osc_en(slow_osc_en), .sys_clk_sel(sys_clk_sel), .watchdog_run(watchdog_run));

/* verification/test_mcu_option_and_clock_setup.sv */
/*
  Self-checking bench: APB tasks and one test sequence run under three
  option sets, each loaded by its own reset. Assumes a zero-wait APB slave.
*/
module test_mcu_option_and_clock_setup;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, psel, penable, pwrite, prog_read_req, pin5_out_low, comparator_out;
  logic [31:0] paddr, pwdata, prdata, last_rd;
  logic        pready, pslverr, last_err, pin_o, pin_oe, ext_rst, comp_irq, gie, slow_en, wdog;
  logic [15:0] word_in, word_out;
  logic [7:0]  port_a_in, port_b_in, wake_a, wake_b;
  logic [4:0]  pwm_raw, pwm_out;
  logic [2:0]  pwm_en, pwm_dbl, clk_sel;
  logic [1:0]  ext_irq, tmr_fast, tmr_dbl, tmr_7, tmr_low, sel;
  int          miscompares, checks;
  mocs_pkg::mocs_option_t option_nvm;
  mocs_pkg::mocs_option_t opts [3];
  mocs_pkg::mocs_xtal_t   xtal;
  localparam logic [7:0] CPU_CMD [4] = '{8'h04, 8'h01, 8'h02, 8'h0C};
  localparam logic       CPU_GIE [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  mocs_top dut (
    .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .option_nvm(option_nvm), .prog_read_req(prog_read_req),
    .prog_word_in(word_in), .prog_word_out(word_out), .port_a_in(port_a_in),
    .port_b_in(port_b_in), .pin5_out_low(pin5_out_low), .comparator_out(comparator_out),
    .pwm_raw(pwm_raw), .pwm_out(pwm_out), .port_a_pin_five_o(pin_o),
    .port_a_pin_five_oe(pin_oe), .external_reset(ext_rst), .wake_a_en(wake_a),
    .wake_b_en(wake_b), .ext_int_req(ext_irq), .comp_int_req(comp_irq),
    .global_int_en(gie), .pwm_clk_en(pwm_en), .pwm_clk_double(pwm_dbl),
    .timer_clk_fast(tmr_fast), .timer_clk_double(tmr_dbl), .timer_pwm_7bit(tmr_7),
    .timer_pwm_lowres(tmr_low), .xtal_ctrl(xtal), .slow_osc_en(slow_en),
    .sys_clk_sel(clk_sel), .watchdog_run(wdog));

  always #2 core_clk = ~core_clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Holds the request until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {24'h000000, a};
    pwdata  <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    last_rd  = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(last_rd, {24'h000000, exp});
  endtask : rdc

  // Register, then output register: two edges before a level is final
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic suite(input mocs_pkg::mocs_option_t o);
    logic [7:0] ob;
    ob = {o.read_protect, o.pwm_double, o.comp_gates_pwm, o.int0_alt_pin,
          o.int1_alt_pin, o.comp_edge[0], o.timer_double, o.timer_7bit};
    sel = {o.int1_alt_pin, o.int0_alt_pin};
    @(posedge core_clk);
    rstn       <= 1'b0;
    option_nvm <= o;
    port_a_in  <= 8'h00;
    port_b_in  <= 8'h00;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rdc(mocs_pkg::OFS_CLOCK_MODE, mocs_pkg::CMODE_RESET);
    check({slow_en, wdog, clk_sel}, 5'h1F);
    rdc(mocs_pkg::OFS_OPTION, ob);
    wr(mocs_pkg::OFS_OPTION, ~ob);
    check(last_err, 1'b1);
    rdc(mocs_pkg::OFS_OPTION, ob);
    wr(8'h34, 8'hFF);
    check(last_err, 1'b1);
    check(word_out, o.read_protect ? 16'h0000 : 16'hA5C3);
    wr(mocs_pkg::OFS_PWM_CTRL, 8'h05);
    wr(mocs_pkg::OFS_TIMER_CTRL, 8'h20);
    wr(mocs_pkg::OFS_TIMER_SCAL, 8'h80);
    wr(mocs_pkg::OFS_COMP_CTRL, 8'h40);
    settle;
    check({pwm_en, pwm_dbl & pwm_en}, {3'h5, o.pwm_double ? 3'h5 : 3'h0});
    check({tmr_fast, tmr_dbl}, {2'h3, o.timer_double ? 2'h3 : 2'h0});
    check({tmr_low, tmr_7}, {2'h3, o.timer_7bit ? 2'h3 : 2'h0});
    check(pwm_out, o.comp_gates_pwm ? 5'h00 : 5'h1F);
    // Nibble one off the fast pattern and scaler bit 7 clear must not count
    wr(mocs_pkg::OFS_TIMER_CTRL, 8'h30);
    wr(mocs_pkg::OFS_TIMER_SCAL, 8'h7F);
    wr(mocs_pkg::OFS_COMP_CTRL, 8'h00);
    settle;
    check({tmr_fast, tmr_low, pwm_out}, 9'h01F);
    wr(mocs_pkg::OFS_INT_EN, 8'h07);
    wr(mocs_pkg::OFS_INT_REQ, 8'h00);
    @(posedge core_clk);
    port_a_in <= {3'h0, ~sel[1], 3'h0, sel[0]};
    port_b_in <= {2'h0, ~sel[0], 4'h0, sel[1]};
    settle;
    check(ext_irq, 2'h0);
    @(posedge core_clk);
    port_a_in <= {3'h0, sel[1], 3'h0, ~sel[0]};
    port_b_in <= {2'h0, sel[0], 4'h0, ~sel[1]};
    settle;
    check(ext_irq, 2'h3);
    wr(mocs_pkg::OFS_INT_REQ, 8'h00);
    @(posedge core_clk);
    comparator_out <= 1'b1;
    settle;
    check(comp_irq, o.comp_edge != mocs_pkg::MOCS_EDGE_FALLING);
    wr(mocs_pkg::OFS_INT_REQ, 8'h00);
    @(posedge core_clk);
    comparator_out <= 1'b0;
    settle;
    check(comp_irq, o.comp_edge != mocs_pkg::MOCS_EDGE_RISING);
    foreach (CPU_CMD[i]) begin
      wr(mocs_pkg::OFS_CPU_CTRL, CPU_CMD[i]);
      settle;
      check(gie, CPU_GIE[i]);
    end
    wr(mocs_pkg::OFS_PORT_DIR, 8'h20);
    @(posedge core_clk);
    pin5_out_low <= 1'b1;
    settle;
    check({pin_o, pin_oe}, 2'h1);
    @(posedge core_clk);
    pin5_out_low <= 1'b0;
    settle;
    check({pin_o, pin_oe}, 2'h0);
    wr(mocs_pkg::OFS_PORT_DIR, 8'h0F);
    wr(mocs_pkg::OFS_DIG_IN_EN, 8'hFF);
    wr(mocs_pkg::OFS_CLOCK_MODE, 8'hF5);
    settle;
    check({wake_a, wake_b, ext_rst}, 17'h1E1E1);
    @(posedge core_clk);
    port_a_in[5] <= 1'b1;
    settle;
    check(ext_rst, 1'b0);
    wr(mocs_pkg::OFS_CRYSTAL, 8'h60);
    settle;
    check(xtal, 3'h3);
    for (int r = 1; r < 4; r++) begin
      wr(mocs_pkg::OFS_CRYSTAL, {1'b1, r[1:0], 5'h00});
      settle;
      check(xtal, {1'b1, r[1:0]});
    end
    // Switch first, stop the slow oscillator in a later write
    wr(mocs_pkg::OFS_CLOCK_MODE, 8'hA4);
    wr(mocs_pkg::OFS_CLOCK_MODE, 8'hA0);
    settle;
    check({clk_sel, slow_en, wdog}, 5'h14);
  endtask : suite

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, pin5_out_low, comparator_out} = 5'h00;
    {paddr, pwdata} = 64'h0;
    {port_a_in, port_b_in} = 16'h0000;
    prog_read_req = 1'b1;
    word_in = 16'hA5C3;
    pwm_raw = 5'h1F;
    opts[0] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, mocs_pkg::MOCS_EDGE_RISING, 1'b1, 1'b1};
    opts[1] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, mocs_pkg::MOCS_EDGE_ALL, 1'b0, 1'b0};
    opts[2] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, mocs_pkg::MOCS_EDGE_FALLING, 1'b0, 1'b1};
    option_nvm = opts[0];
    foreach (opts[i]) suite(opts[i]);
    report_and_stop;
  end

  // Three suites take a few hundred cycles; far past that means a hang
  initial begin
    #60000;
    miscompares++;
    report_and_stop;
  end
endmodule : test_mcu_option_and_clock_setup
